// [verilog/edo_ctrl_pkg.sv]
package edo_ctrl_pkg;
   // Clock and power-on figures.
   localparam int CLK_PERIOD_PS       = 8000;
   localparam int POWER_UP_WAIT_US    = 200;
   localparam int POWER_UP_CYCLES     = (POWER_UP_WAIT_US * 1000000) / CLK_PERIOD_PS;
   localparam int INIT_ROW_CYCLES     = 8;
   // Refresh figures: 1024 rows every 16 ms, spread evenly.
   localparam int REFRESH_ROWS        = 1024;
   localparam int REFRESH_INTERVAL_US = 16000;
   localparam int REFRESH_SPACING     =
      (REFRESH_INTERVAL_US * 1000000) / (CLK_PERIOD_PS * REFRESH_ROWS);
   // Strobe timing: least times in ns, rounded up to whole cycles.
   localparam int ROW_ACTIVE_NS           = 60;
   localparam int ROW_PRECHARGE_TIME_NS   = 40;
   localparam int COLUMN_PRECHARGE_TIME_NS = 10;
   localparam int ROW_TO_COL_NS           = 20;
   localparam int COL_ADDR_HOLD_NS        = 40;
   localparam int READ_ACCESS_NS          = 60;
   localparam int CAS_PULSE_NS            = 15;
   localparam int ROW_ACTIVE_CYC  = (ROW_ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ROW_PRE_CYC     =
      (ROW_PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int COL_PRE_CYC     =
      (COLUMN_PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ROW_TO_COL_CYC  = (ROW_TO_COL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int COL_HOLD_CYC    =
      (COL_ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CAS_PULSE_CYC   = (CAS_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIMER_W         = 16;
endpackage : edo_ctrl_pkg

// [verilog/edo_dram_host.sv]
`timescale 1ns/10ps
`default_nettype none
module edo_dram_host
   import edo_ctrl_pkg::*;
#(
   parameter int POWER_UP_WAIT   = POWER_UP_CYCLES,
   parameter int REFRESH_PERIOD  = REFRESH_SPACING
) (
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   input  wire logic        clk_en_in,
   input  wire logic        req_valid_in,
   input  wire logic        req_write_in,
   input  wire logic [19:0] req_addr_in,
   input  wire logic [1:0]  req_byte_en_in,
   input  wire logic [15:0] req_wdata_in,
   output logic             req_ready_out,
   output logic             rdata_valid_out,
   output logic [15:0]      rdata_out,
   output logic             init_done_out,
   output logic [9:0]       mux_address_out,
   output logic             row_strobe_n_out,
   output logic             lower_byte_strobe_n_out,
   output logic             upper_byte_strobe_n_out,
   output logic             write_gate_n_out,
   output logic             output_gate_n_out,
   input  wire logic [15:0] data_lines_in,
   output logic [15:0]      data_lines_out,
   output logic [15:0]      data_lines_oe_out
);

   initial begin
      if (POWER_UP_WAIT < 1 || POWER_UP_WAIT >= 2 ** TIMER_W * 8 ||
          REFRESH_PERIOD < 64 || REFRESH_PERIOD >= 2 ** TIMER_W) begin
         $error("edo_dram_host: timing parameter out of range.");
      end
   end

   typedef enum logic [3:0] {
      ST_POWER_WAIT, ST_IDLE, ST_ROW, ST_COL, ST_PAGE_WAIT,
      ST_RFSH_CAS, ST_RFSH_ROW, ST_END, ST_PRECHARGE
   } state_t;

   // Clamps a least time in cycles to one or more, so that a count of zero never occurs.
   function automatic logic [TIMER_W-1:0] cyc(input int n);
      cyc = TIMER_W'(n < 1 ? 1 : n);
   endfunction : cyc

   state_t            state_q, state_d;
   logic [18:0]       timer_q, timer_d;
   logic [TIMER_W-1:0] rfsh_cnt_q, rfsh_cnt_d;
   logic [TIMER_W-1:0] ras_cnt_q, ras_cnt_d;
   logic [3:0]        init_cnt_q, init_cnt_d;
   logic              init_q, init_d;
   logic              rfsh_due_q, rfsh_due_d;
   logic              overrun_q, overrun_d;
   logic [9:0]        row_q, row_d;
   logic              wr_q, wr_d;
   logic [1:0]        be_q, be_d;
   logic [15:0]       wdata_q, wdata_d;
   logic [9:0]        addr_q, addr_d;
   logic              ras_n_q, ras_n_d;
   logic              lower_byte_strobe_n_n_q, lower_byte_strobe_n_n_d;
   logic              upper_byte_strobe_n_n_q, upper_byte_strobe_n_n_d;
   logic              we_n_q, we_n_d;
   logic              oe_n_q, oe_n_d;
   logic [15:0]       rdata_q, rdata_d;
   logic              rvalid_q, rvalid_d;
   logic              page_hit;
   logic [9:0]        col_q, col_d;

   // A request for the open row may reuse it without a new row strobe.
   assign page_hit = req_valid_in && (req_addr_in[19:10] == row_q) && !rfsh_due_q;
   // Ready in page wait only once column precharge is over, so a taken request is never lost.
   assign req_ready_out = init_q && !rfsh_due_q && !overrun_q &&
                          ((state_q == ST_IDLE) ||
                           (state_q == ST_PAGE_WAIT && timer_q == '0 && page_hit));

   // Refresh pacing runs independently of the access machine.
   always_comb begin
      rfsh_cnt_d = rfsh_cnt_q;
      rfsh_due_d = rfsh_due_q;
      overrun_d  = overrun_q;
      // The restart taken from idle consumes the overrun; a new tick below still wins.
      if (state_q == ST_POWER_WAIT || (state_q == ST_IDLE && overrun_q)) begin
         overrun_d = 1'b0;
      end
      if (state_q == ST_RFSH_ROW) begin
         rfsh_due_d = 1'b0;
      end
      if (!init_q) begin
         rfsh_cnt_d = '0;
      end else if (rfsh_cnt_q >= TIMER_W'(REFRESH_PERIOD - 1)) begin
         rfsh_cnt_d = '0;
         // A tick arriving while one is still owed means the window was missed.
         if (rfsh_due_q && state_q != ST_RFSH_ROW) begin
            overrun_d = 1'b1;
         end
         rfsh_due_d = 1'b1;
      end else begin
         rfsh_cnt_d = rfsh_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         rfsh_cnt_q <= '0;
         rfsh_due_q <= 1'b0;
         overrun_q  <= 1'b0;
      end else if (clk_en_in) begin
         rfsh_cnt_q <= rfsh_cnt_d;
         rfsh_due_q <= rfsh_due_d;
         overrun_q  <= overrun_d;
      end
   end

   // Main strobe sequencer; pins change only from registers to avoid glitches.
   always_comb begin
      state_d    = state_q;
      timer_d    = (timer_q != '0) ? timer_q - 19'h00001 : timer_q;
      ras_cnt_d  = (ras_cnt_q != '0) ? ras_cnt_q - 16'h0001 : ras_cnt_q;
      init_cnt_d = init_cnt_q;
      init_d     = init_q;
      row_d      = row_q;
      wr_d       = wr_q;
      be_d       = be_q;
      wdata_d    = wdata_q;
      addr_d     = addr_q;
      ras_n_d    = ras_n_q;
      lower_byte_strobe_n_n_d   = lower_byte_strobe_n_n_q;
      upper_byte_strobe_n_n_d   = upper_byte_strobe_n_n_q;
      we_n_d     = we_n_q;
      oe_n_d     = oe_n_q;
      rdata_d    = rdata_q;
      rvalid_d   = 1'b0;
      unique case (state_q)
         ST_POWER_WAIT: begin
            ras_n_d = 1'b1;
            if (timer_q == '0) begin
               state_d = ST_PRECHARGE;
               timer_d = 19'(cyc(ROW_PRE_CYC));
            end
         end
         ST_IDLE: begin
            if (overrun_q) begin
               init_d     = 1'b0;
               init_cnt_d = '0;
            end
            if (rfsh_due_q || !init_q || overrun_q) begin
               // Column strobes fall first so the row fall selects refresh.
               lower_byte_strobe_n_n_d = 1'b0;
               upper_byte_strobe_n_n_d = 1'b0;
               state_d  = ST_RFSH_CAS;
               timer_d  = 19'(cyc(1));
            end else if (req_valid_in) begin
               row_d   = req_addr_in[19:10];
               addr_d  = req_addr_in[19:10];
               wr_d    = req_write_in;
               be_d    = req_byte_en_in;
               wdata_d = req_wdata_in;
               ras_n_d = 1'b0;
               ras_cnt_d = cyc(ROW_ACTIVE_CYC);
               state_d = ST_ROW;
               timer_d = 19'(cyc(ROW_TO_COL_CYC));
            end
         end
         ST_ROW: begin
            if (timer_q == '0) begin
               addr_d  = col_q;
               state_d = ST_COL;
            end
         end
         ST_COL: begin
            // Column phase: address and write data set up a cycle before strobes fall; gates fall on the same edge as the strobes.
            if (lower_byte_strobe_n_n_q && upper_byte_strobe_n_n_q && timer_q == '0) begin
               lower_byte_strobe_n_n_d = ~be_q[0];
               upper_byte_strobe_n_n_d = ~be_q[1];
               we_n_d   = ~wr_q;
               oe_n_d   = wr_q;
               timer_d  = 19'(wr_q ? cyc(CAS_PULSE_CYC) :
                          cyc(READ_ACCESS_CYC > COL_HOLD_CYC ? READ_ACCESS_CYC : COL_HOLD_CYC));
            end else if (timer_q == '0) begin
               if (!wr_q) begin
                  rdata_d  = data_lines_in;
                  rvalid_d = 1'b1;
               end
               lower_byte_strobe_n_n_d = 1'b1;
               upper_byte_strobe_n_n_d = 1'b1;
               we_n_d   = 1'b1;
               state_d  = ST_PAGE_WAIT;
               timer_d  = 19'(cyc(COL_PRE_CYC));
            end
         end
         ST_PAGE_WAIT: begin
            if (timer_q == '0 && req_ready_out && req_valid_in) begin
               wr_d    = req_write_in;
               be_d    = req_byte_en_in;
               wdata_d = req_wdata_in;
               addr_d  = req_addr_in[9:0];
               oe_n_d  = 1'b1;
               state_d = ST_COL;
            end else if (timer_q == '0 && ras_cnt_q == '0 && !page_hit) begin
               state_d = ST_END;
            end
         end
         ST_RFSH_CAS: begin
            if (timer_q == '0) begin
               ras_n_d   = 1'b0;
               ras_cnt_d = cyc(ROW_ACTIVE_CYC);
               state_d   = ST_RFSH_ROW;
            end
         end
         ST_RFSH_ROW: begin
            if (ras_cnt_q == '0) begin
               state_d = ST_END;
            end
         end
         ST_END: begin
            ras_n_d  = 1'b1;
            lower_byte_strobe_n_n_d = 1'b1;
            upper_byte_strobe_n_n_d = 1'b1;
            we_n_d   = 1'b1;
            oe_n_d   = 1'b1;
            if (!init_q) begin
               init_cnt_d = init_cnt_q + 4'h1;
               if (init_cnt_q == 4'(INIT_ROW_CYCLES - 1)) begin
                  init_d = 1'b1;
               end
            end
            state_d = ST_PRECHARGE;
            timer_d = 19'(cyc(ROW_PRE_CYC > COL_PRE_CYC ? ROW_PRE_CYC : COL_PRE_CYC));
         end
         ST_PRECHARGE: begin
            if (timer_q == '0) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   // The column part is captured with the request and held through the access.
   always_comb begin
      col_d = col_q;
      if (state_q == ST_IDLE && req_valid_in && req_ready_out) begin
         col_d = req_addr_in[9:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_q    <= ST_POWER_WAIT;
         timer_q    <= 19'(POWER_UP_WAIT);
         ras_cnt_q  <= '0;
         init_cnt_q <= '0;
         init_q     <= 1'b0;
         row_q      <= '0;
         col_q      <= '0;
         wr_q       <= 1'b0;
         be_q       <= '0;
         wdata_q    <= '0;
         addr_q     <= '0;
         ras_n_q    <= 1'b1;
         lower_byte_strobe_n_n_q   <= 1'b1;
         upper_byte_strobe_n_n_q   <= 1'b1;
         we_n_q     <= 1'b1;
         oe_n_q     <= 1'b1;
         rdata_q    <= '0;
         rvalid_q   <= 1'b0;
      end else if (clk_en_in) begin
         state_q    <= state_d;
         timer_q    <= timer_d;
         ras_cnt_q  <= ras_cnt_d;
         init_cnt_q <= init_cnt_d;
         init_q     <= init_d;
         row_q      <= row_d;
         col_q      <= col_d;
         wr_q       <= wr_d;
         be_q       <= be_d;
         wdata_q    <= wdata_d;
         addr_q     <= addr_d;
         ras_n_q    <= ras_n_d;
         lower_byte_strobe_n_n_q   <= lower_byte_strobe_n_n_d;
         upper_byte_strobe_n_n_q   <= upper_byte_strobe_n_n_d;
         we_n_q     <= we_n_d;
         oe_n_q     <= oe_n_d;
         rdata_q    <= rdata_d;
         rvalid_q   <= rvalid_d;
      end
   end

   // Write data is driven only during the column phase, only for enabled byte lanes,
   // and never in a refresh, so the bus is free whenever the device may drive it.
   always_comb begin
      data_lines_out    = wdata_q;
      data_lines_oe_out = 16'h0000;
      if (wr_q && (state_q == ST_COL)) begin
         data_lines_oe_out = {{8{be_q[1]}}, {8{be_q[0]}}};
      end
   end

   assign mux_address_out         = addr_q;
   assign row_strobe_n_out        = ras_n_q;
   assign lower_byte_strobe_n_out = lower_byte_strobe_n_n_q;
   assign upper_byte_strobe_n_out = upper_byte_strobe_n_n_q;
   assign write_gate_n_out        = we_n_q;
   assign output_gate_n_out       = oe_n_q;
   assign rdata_out               = rdata_q;
   assign rdata_valid_out         = rvalid_q;
   assign init_done_out           = init_q;

endmodule : edo_dram_host
`default_nettype wire

// [verif/edo_dram_host_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module edo_dram_host_monitor
   import edo_ctrl_pkg::*;
#(
   parameter int POWER_UP_WAIT  = POWER_UP_CYCLES,
   parameter int REFRESH_PERIOD = REFRESH_SPACING
) (
   input wire logic        sys_clk_in,
   input wire logic        reset_in,
   input wire logic        clk_en_in,
   input wire logic        req_ready_out,
   input wire logic        rdata_valid_out,
   input wire logic        init_done_out,
   input wire logic        row_strobe_n_out,
   input wire logic        lower_byte_strobe_n_out,
   input wire logic        upper_byte_strobe_n_out,
   input wire logic        write_gate_n_out,
   input wire logic        output_gate_n_out,
   input wire logic [15:0] data_lines_oe_out
);
   wire         ras = row_strobe_n_out;
   wire         lcs = lower_byte_strobe_n_out;
   wire         ucs = upper_byte_strobe_n_out;
   logic        ras_q;
   wire         fall = ras_q && !ras;
   logic [31:0] up_q;
   logic [31:0] gap_q;
   logic [7:0]  open_q;
   logic [3:0]  wake_q;
   // Uptime and refresh gap count only enabled cycles, since a frozen controller cannot move its pins.
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ras_q  <= 1'b1;
         up_q   <= 32'h0;
         gap_q  <= 32'h0;
         open_q <= 8'h00;
         wake_q <= 4'h0;
      end else begin
         ras_q  <= ras;
         up_q   <= up_q + 32'(clk_en_in);
         gap_q  <= fall ? 32'h0 : gap_q + 32'(clk_en_in);
         open_q <= fall ? 8'h00 : open_q + 8'(open_q != 8'hFF);
         wake_q <= init_done_out ? 4'h0 : wake_q + 4'(fall && wake_q != 4'hF);
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   sequence row_open_s;
      $fell(ras) && lcs && ucs;
   endsequence
   sequence col_wait_s;
      (lcs && ucs) [*3];
   endsequence
   reset_idle_a: assert property (disable iff (1'b0) reset_in |=>
      ras && lcs && ucs && data_lines_oe_out == 16'h0000 && !init_done_out)
      else $error("pins not idle after reset");
   row_active_a: assert property ($fell(ras) |-> !ras [*8])
      else $error("row strobe pulse too short");
   row_precharge_a: assert property ($rose(ras) |-> ras [*5])
      else $error("row precharge too short");
   col_precharge_a: assert property ($rose(lcs) |-> lcs [*2])
      else $error("column precharge too short");
   row_to_col_a: assert property (row_open_s |-> col_wait_s)
      else $error("column strobe too soon after row strobe");
   write_data_a: assert property (!ras && !write_gate_n_out &&
      ($fell(lcs) || ($fell(write_gate_n_out) && !lcs)) |-> data_lines_oe_out[7:0] == 8'hFF)
      else $error("write data not driven at write start");
   no_contend_a: assert property (!output_gate_n_out |-> data_lines_oe_out == 16'h0000)
      else $error("data driven while output gate open");
   read_access_a: assert property (rdata_valid_out |-> open_q >= 8'h08)
      else $error("read data taken before access time");
   wake_first_a: assert property ($fell(ras) |-> up_q >= POWER_UP_WAIT - 1)
      else $error("row strobe before power-up pause");
   init_count_a: assert property ($rose(init_done_out) |-> wake_q >= 4'h8)
      else $error("init done before eight wake-up cycles");
   ready_init_a: assert property (!init_done_out |-> !req_ready_out)
      else $error("request accepted before init");
   refresh_gap_a: assert property (init_done_out |-> gap_q <= REFRESH_PERIOD + 64)
      else $error("refresh gap too long");
endmodule : edo_dram_host_monitor
bind edo_dram_host edo_dram_host_monitor #(
   .POWER_UP_WAIT(POWER_UP_WAIT), .REFRESH_PERIOD(REFRESH_PERIOD)) u_mon (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
   .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
   .init_done_out(init_done_out), .row_strobe_n_out(row_strobe_n_out),
   .lower_byte_strobe_n_out(lower_byte_strobe_n_out),
   .upper_byte_strobe_n_out(upper_byte_strobe_n_out), .write_gate_n_out(write_gate_n_out),
   .output_gate_n_out(output_gate_n_out), .data_lines_oe_out(data_lines_oe_out));
`default_nettype wire

// [verif/edo_dram_model.sv]
`timescale 1ns/10ps
`default_nettype none
module edo_dram_model #(
   parameter int ACCESS_NS = 30
) (
   input  wire logic [9:0]  mux_address_in,
   input  wire logic        row_strobe_n_in,
   input  wire logic        lower_byte_strobe_n_in,
   input  wire logic        upper_byte_strobe_n_in,
   input  wire logic        write_gate_n_in,
   input  wire logic        output_gate_n_in,
   input  wire logic [15:0] wdata_in,
   output logic [15:0]      rdata_out,
   output int               refresh_cnt_out
);
   wire         lo = lower_byte_strobe_n_in;
   wire         hi = upper_byte_strobe_n_in;
   wire         we = write_gate_n_in;
   logic [15:0] mem [logic [19:0]];
   logic [9:0]  row_q;
   logic [19:0] adr_q;
   logic        cbr_q = 1'b0;
   logic [15:0] q_q = 16'h0000;
   logic [1:0]  drv_q = 2'b00;
   wire  [1:0]  lane_on = drv_q & {2{!output_gate_n_in && !cbr_q}};
   initial refresh_cnt_out = 0;
   // A column strobe already low at the row fall selects a counter refresh.
   always @(negedge row_strobe_n_in) begin
      cbr_q = !(lo && hi);
      if (cbr_q) refresh_cnt_out++;
      // Address and strobe change on one clock edge, so look just after it.
      #1 row_q = mux_address_in;
   end
   // Each strobe fall latches the column and ends the held data of the last read.
   always @(negedge lo or negedge hi or negedge we) begin
      if (!row_strobe_n_in && !cbr_q) begin
         adr_q = {row_q, mux_address_in};
         drv_q = 2'b00;
         if (!mem.exists(adr_q)) mem[adr_q] = 16'h0000;
         if (!we && !lo) mem[adr_q][7:0] = wdata_in[7:0];
         if (!we && !hi) mem[adr_q][15:8] = wdata_in[15:8];
         q_q <= #(ACCESS_NS) mem[adr_q];
         drv_q <= #(ACCESS_NS) ~{hi, lo} & {2{we}};
      end
   end
   // Closing the output gate releases the lines.
   always @(posedge output_gate_n_in) drv_q = 2'b00;
   // Released lanes show the inverse so a stale capture never matches.
   assign rdata_out = q_q ^ ~{{8{lane_on[1]}}, {8{lane_on[0]}}};
endmodule : edo_dram_model
`default_nettype wire

// [verif/tb_edo_dram_host.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_edo_dram_host;
   import edo_ctrl_pkg::*;
   localparam int PWR  = 50;
   localparam int RPER = 200;
   logic        clk;
   logic        rst = 1'b1;
   logic        en = 1'b1;
   logic        vld = 1'b0;
   logic        wr = 1'b0;
   logic [19:0] adr = 20'h00000;
   logic [1:0]  be = 2'h3;
   logic [15:0] wd = 16'h0000;
   logic [15:0] din, dout, doe, rdat, snap;
   logic        rdy, rv, idone, ras, lcs, ucs, wg, og;
   logic [9:0]  ma;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          nref, n0;
   logic [15:0] ref_m [logic [19:0]];
   edo_dram_host #(.POWER_UP_WAIT(PWR), .REFRESH_PERIOD(RPER)) DUT (
      .sys_clk_in(clk), .reset_in(rst), .clk_en_in(en), .req_valid_in(vld),
      .req_write_in(wr), .req_addr_in(adr), .req_byte_en_in(be), .req_wdata_in(wd),
      .req_ready_out(rdy), .rdata_valid_out(rv), .rdata_out(rdat), .init_done_out(idone),
      .mux_address_out(ma), .row_strobe_n_out(ras), .lower_byte_strobe_n_out(lcs),
      .upper_byte_strobe_n_out(ucs), .write_gate_n_out(wg), .output_gate_n_out(og),
      .data_lines_in(din), .data_lines_out(dout), .data_lines_oe_out(doe));
   edo_dram_model u_mem (
      .mux_address_in(ma), .row_strobe_n_in(ras), .lower_byte_strobe_n_in(lcs),
      .upper_byte_strobe_n_in(ucs), .write_gate_n_in(wg), .output_gate_n_in(og),
      .wdata_in(dout ^ ~doe), .rdata_out(din), .refresh_cnt_out(nref));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // A request is held until ready is seen high at a rising edge.
   task automatic req(input logic w, input logic [19:0] a, input logic [1:0] b,
                      input logic [15:0] d);
      @(posedge clk);
      vld <= 1'b1;
      wr <= w;
      adr <= a;
      be <= b;
      wd <= d;
      @(negedge clk);
      for (int i = 0; i < 300 && rdy !== 1'b1; i++) @(negedge clk);
      @(posedge clk);
      vld <= 1'b0;
   endtask : req
   task automatic write(input logic [19:0] a, input logic [1:0] b, input logic [15:0] d);
      if (!ref_m.exists(a)) ref_m[a] = 16'h0000;
      if (b[0]) ref_m[a][7:0] = d[7:0];
      if (b[1]) ref_m[a][15:8] = d[15:8];
      req(1'b1, a, b, d);
   endtask : write
   // A freeze in mid-read must leave strobes, gates and address where they stood.
   task automatic read(input logic [19:0] a, input int frz);
      req(1'b0, a, 2'h3, 16'h0000);
      if (frz > 0) begin
         en <= 1'b0;
         @(negedge clk);
         snap = {ras, lcs, ucs, wg, og, 1'b0, ma};
         repeat (frz) @(negedge clk);
         check({ras, lcs, ucs, wg, og, 1'b0, ma}, snap);
         @(posedge clk);
         en <= 1'b1;
      end
      @(negedge clk);
      for (int i = 0; i < 100 && rv !== 1'b1; i++) @(negedge clk);
      check(rv ? rdat : ~ref_m[a], ref_m[a]);
   endtask : read
   task automatic t_init;
      for (int i = 0; i < 3000 && idone !== 1'b1; i++) @(negedge clk);
      check({15'h0000, idone}, 16'h0001);
      check(16'(nref >= 8), 16'h0001);
   endtask : t_init
   // Word, then single-byte writes, read back across the extreme row and column.
   task automatic t_bytes;
      write(20'hFFFFF, 2'h3, 16'hA5C3);
      write(20'hFFFFF, 2'h1, 16'h0011);
      write(20'h00000, 2'h3, 16'h5A3C);
      write(20'hFFFFF, 2'h2, 16'h2200);
      read(20'hFFFFF, 0);
      read(20'h00000, 20);
   endtask : t_bytes
   // Same-row traffic mixes reads and writes in one open row.
   task automatic t_page;
      write(20'h2A801, 2'h3, 16'h1357);
      write(20'h2ABFF, 2'h3, 16'h9BDF);
      read(20'h2A801, 0);
      write(20'h2A802, 2'h3, 16'hFEDC);
      read(20'h2ABFF, 0);
      read(20'h2A802, 0);
   endtask : t_page
   // Idle time is filled with evenly spaced refreshes.
   task automatic t_refresh;
      n0 = nref;
      repeat (10 * RPER) @(negedge clk);
      check(16'(nref - n0 >= 9 && nref - n0 <= 11), 16'h0001);
      read(20'hFFFFF, 0);
   endtask : t_refresh
   // Hang guard: the whole sequence needs well under this many cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({ras, lcs, ucs, rdy, idone, doe[10:0]}, 16'hE000);
      @(posedge clk);
      rst <= 1'b0;
      t_init();
      t_bytes();
      t_page();
      t_refresh();
      finish_test();
   end
endmodule : tb_edo_dram_host
`default_nettype wire
